// file: battery_monitor.sv
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module battery_monitor
	import battery_monitor_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [battery_monitor_pkg::VOLT_W-1:0] battery_voltage,
	input wire logic battery_valid,
	input wire logic trip,
	input wire logic power_good_pin,
	output logic undervoltage_flag,
	output logic overvoltage_flag,
	output logic qualified_battery_element,
	output logic alarm_contact,
	output logic reclose_lockout_drive,
	output logic event_report_trigger,
	output logic [battery_monitor_pkg::VOLT_W-1:0] event_voltage,
	output logic irq
);
	import battery_monitor_pkg::*;

	// ==========================================================
	// Bus and register state
	logic wr_pend_reg;
	logic wr_pend_next;
	logic [ADDR_W-1:0] wr_addr_reg;
	logic [ADDR_W-1:0] wr_addr_next;
	logic [DATA_W-1:0] hrdata_reg;
	logic [DATA_W-1:0] hrdata_next;
	logic hreadyout_reg;
	logic hresp_reg;
	logic [PICKUP_W-1:0] low_reg;
	logic [PICKUP_W-1:0] low_next;
	logic [PICKUP_W-1:0] high_reg;
	logic [PICKUP_W-1:0] high_next;
	logic [QUAL_W-1:0] qual_delay_reg;
	logic [QUAL_W-1:0] qual_delay_next;
	logic [ROUTE_W-1:0] route_reg;
	logic [ROUTE_W-1:0] route_next;
	logic [EV_W-1:0] int_status_reg;
	logic [EV_W-1:0] int_status_next;
	logic [EV_W-1:0] int_mask_reg;
	logic [EV_W-1:0] int_mask_next;
	logic [EV_W-1:0] int_clear;
	logic irq_reg;
	logic irq_next;
	logic addr_ok;

	// ==========================================================
	// Monitor state
	logic [VOLT_W-1:0] meter_reg;
	logic [VOLT_W-1:0] meter_next;
	logic under_reg;
	logic under_next;
	logic over_reg;
	logic over_next;
	logic element;
	logic qual_wire;
	logic qual_prev_reg;
	logic trip_prev_reg;
	logic pg_meta_reg;
	logic pg_sync_reg;
	logic dip;
	logic trip_rise;
	logic report_reg;
	logic report_next;
	logic [VOLT_W-1:0] ev_volt_reg;
	logic [VOLT_W-1:0] ev_volt_next;
	logic alarm_reg;
	logic alarm_next;
	logic lockout_reg;
	logic lockout_next;
	logic [EV_W-1:0] ev_set;

	// ==========================================================
	// Monitor logic
	always_comb begin
		meter_next = battery_valid ? battery_voltage : meter_reg;
		// Both compares see the same sample; the pickups never interact
		under_next = pickup_flag(low_reg, meter_reg, 1'b0);
		over_next = pickup_flag(high_reg, meter_reg, 1'b1);
		// Band mode suits a low pickup set above the high pickup
		element = route_reg[ROUTE_BAND_BIT] ? (under_reg & over_reg)
			: (under_reg | over_reg);
		dip = qual_prev_reg & ~qual_wire;
		trip_rise = trip & ~trip_prev_reg;
		report_next = trip_rise | dip;
		ev_volt_next = report_next ? meter_reg : ev_volt_reg;
		// Contacts can never close while power is gone
		alarm_next = qual_wire & pg_sync_reg;
		lockout_next = route_reg[ROUTE_LOCKOUT_BIT] & ~qual_wire
			& pg_sync_reg;
		ev_set = '0;
		ev_set[EV_UNDER] = under_next & ~under_reg;
		ev_set[EV_OVER] = over_next & ~over_reg;
		ev_set[EV_DIP] = dip;
		ev_set[EV_REPORT] = report_next;
	end

	qualify_timer u_qualify_timer (
		.clk(clk),
		.reset_n(reset_n),
		.element(element),
		.delay(qual_delay_reg),
		.qualified(qual_wire)
	);

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			meter_reg <= VOLT_RST;
			under_reg <= 1'b0;
			over_reg <= 1'b0;
			qual_prev_reg <= 1'b0;
			trip_prev_reg <= 1'b0;
			pg_meta_reg <= 1'b0;
			pg_sync_reg <= 1'b0;
			report_reg <= 1'b0;
			ev_volt_reg <= VOLT_RST;
			alarm_reg <= 1'b0;
			lockout_reg <= 1'b0;
		end else begin
			meter_reg <= meter_next;
			under_reg <= under_next;
			over_reg <= over_next;
			qual_prev_reg <= qual_wire;
			trip_prev_reg <= trip;
			pg_meta_reg <= power_good_pin;
			pg_sync_reg <= pg_meta_reg;
			report_reg <= report_next;
			ev_volt_reg <= ev_volt_next;
			alarm_reg <= alarm_next;
			lockout_reg <= lockout_next;
		end
	end

	// ==========================================================
	// Bus slave and registers
	always_comb begin
		low_next = low_reg;
		high_next = high_reg;
		qual_delay_next = qual_delay_reg;
		route_next = route_reg;
		int_mask_next = int_mask_reg;
		int_clear = '0;
		hrdata_next = hrdata_reg;
		addr_ok = hsel && hready && htrans[HTRANS_ACTIVE_BIT];
		wr_pend_next = addr_ok && hwrite && (haddr[31:ADDR_W] == '0);
		wr_addr_next = haddr[ADDR_W-1:0];
		// Read data is fetched in the address phase, so that hrdata
		// leaves a flip-flop with no wait state
		if (addr_ok && !hwrite) begin
			hrdata_next = WORD_ZERO;
			if (haddr[31:ADDR_W] == '0) begin
				case (haddr[ADDR_W-1:0])
					OFS_LOW_PICKUP: hrdata_next[PICKUP_W-1:0] = low_reg;
					OFS_HIGH_PICKUP: hrdata_next[PICKUP_W-1:0] = high_reg;
					OFS_STATE: begin
						hrdata_next[ST_UNDER_BIT] = under_reg;
						hrdata_next[ST_OVER_BIT] = over_reg;
						hrdata_next[ST_QUAL_BIT] = qual_wire;
						hrdata_next[ST_POWER_BIT] = pg_sync_reg;
					end
					OFS_METER: hrdata_next[VOLT_W-1:0] = meter_reg;
					OFS_INT_STATUS: hrdata_next[EV_W-1:0] = int_status_reg;
					OFS_INT_MASK: hrdata_next[EV_W-1:0] = int_mask_reg;
					OFS_QUAL_DELAY: hrdata_next[QUAL_W-1:0] = qual_delay_reg;
					OFS_EVENT_VOLT: hrdata_next[VOLT_W-1:0] = ev_volt_reg;
					OFS_ROUTE: hrdata_next[ROUTE_W-1:0] = route_reg;
					default: hrdata_next = WORD_ZERO;
				endcase
			end
		end
		if (wr_pend_reg) begin
			case (wr_addr_reg)
				OFS_LOW_PICKUP: begin
					low_next = {hwdata[PICKUP_ON_BIT],
						clamp_pickup(hwdata[VOLT_W-1:0])};
				end
				OFS_HIGH_PICKUP: begin
					high_next = {hwdata[PICKUP_ON_BIT],
						clamp_pickup(hwdata[VOLT_W-1:0])};
				end
				OFS_INT_STATUS: int_clear = hwdata[EV_W-1:0];
				OFS_INT_MASK: int_mask_next = hwdata[EV_W-1:0];
				OFS_QUAL_DELAY: qual_delay_next = hwdata[QUAL_W-1:0];
				OFS_ROUTE: route_next = hwdata[ROUTE_W-1:0];
				default: int_clear = '0;
			endcase
		end
		// A new event in the clearing cycle survives the clear
		int_status_next = (int_status_reg & ~int_clear) | ev_set;
		irq_next = |(int_status_next & int_mask_next);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
			hrdata_reg <= WORD_ZERO;
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
			low_reg <= PICKUP_RST;
			high_reg <= PICKUP_RST;
			qual_delay_reg <= QUAL_DELAY_RST;
			route_reg <= ROUTE_RST;
			int_status_reg <= EV_RST;
			int_mask_reg <= EV_RST;
			irq_reg <= 1'b0;
		end else begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg <= hrdata_next;
			hreadyout_reg <= 1'b1;
			hresp_reg <= 1'b0;
			low_reg <= low_next;
			high_reg <= high_next;
			qual_delay_reg <= qual_delay_next;
			route_reg <= route_next;
			int_status_reg <= int_status_next;
			int_mask_reg <= int_mask_next;
			irq_reg <= irq_next;
		end
	end

	// ==========================================================
	// Outputs
	assign hreadyout = hreadyout_reg;
	assign hrdata = hrdata_reg;
	assign hresp = hresp_reg;
	assign undervoltage_flag = under_reg;
	assign overvoltage_flag = over_reg;
	assign qualified_battery_element = qual_wire;
	assign alarm_contact = alarm_reg;
	assign reclose_lockout_drive = lockout_reg;
	assign event_report_trigger = report_reg;
	assign event_voltage = ev_volt_reg;
	assign irq = irq_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_under_flag_set: assert property (
		(low_reg[PICKUP_ON_BIT] && meter_reg <= low_reg[VOLT_W-1:0])
		|=> undervoltage_flag)
		else $error("undervoltage flag missed a low voltage");

	a_under_flag_clr: assert property (
		(meter_reg > low_reg[VOLT_W-1:0]) |=> !undervoltage_flag)
		else $error("undervoltage flag set above pickup");

	a_over_flag_set: assert property (
		(high_reg[PICKUP_ON_BIT] && meter_reg >= high_reg[VOLT_W-1:0])
		|=> overvoltage_flag)
		else $error("overvoltage flag missed a high voltage");

	a_over_flag_clr: assert property (
		(meter_reg < high_reg[VOLT_W-1:0]) |=> !overvoltage_flag)
		else $error("overvoltage flag set below pickup");

	a_pickup_in_range: assert property (
		$changed(low_reg) |-> (low_reg[VOLT_W-1:0] >= PICKUP_MIN
		&& low_reg[VOLT_W-1:0] <= PICKUP_MAX))
		else $error("low pickup outside its range");

	a_pickups_apart: assert property (
		(wr_pend_reg && wr_addr_reg == OFS_LOW_PICKUP) |=> $stable(high_reg))
		else $error("low pickup write disturbed high pickup");

	a_contacts_unpowered: assert property (
		!pg_sync_reg |=> (!alarm_contact && !reclose_lockout_drive))
		else $error("contact closed without power");

	a_trip_reports: assert property (
		(trip && !trip_prev_reg) |=> event_report_trigger ##1
		(!event_report_trigger || $past(dip)))
		else $error("trip gave no event report");

	a_report_voltage: assert property (
		event_report_trigger |-> event_voltage == $past(meter_reg))
		else $error("event report lost the battery voltage");

	a_meter_readout: assert property (
		(addr_ok && !hwrite && haddr == {24'h000000, OFS_METER})
		|=> hrdata[VOLT_W-1:0] == $past(meter_reg))
		else $error("meter read returned a wrong voltage");

	a_lockout_drive: assert property (
		(route_reg[ROUTE_LOCKOUT_BIT] && pg_sync_reg && $fell(qual_wire))
		|=> reclose_lockout_drive)
		else $error("element dropout did not lock out reclosing");

	a_off_holds_low: assert property (
		(!low_reg[PICKUP_ON_BIT] && !high_reg[PICKUP_ON_BIT])
		|=> (!undervoltage_flag && !overvoltage_flag))
		else $error("flag set while its pickup is off");

	a_high_in_range: assert property (
		$changed(high_reg) |-> (high_reg[VOLT_W-1:0] >= PICKUP_MIN
		&& high_reg[VOLT_W-1:0] <= PICKUP_MAX))
		else $error("high pickup outside its range");

	a_highs_apart: assert property (
		(wr_pend_reg && wr_addr_reg == OFS_HIGH_PICKUP) |=> $stable(low_reg))
		else $error("high pickup write disturbed low pickup");

	a_dip_reports: assert property (
		$fell(qual_wire)
		|=> (event_report_trigger && event_voltage == $past(meter_reg)))
		else $error("element dropout gave no event report");

	a_status_set_wins: assert property (
		(ev_set != '0)
		|=> ((int_status_reg & $past(ev_set)) == $past(ev_set)))
		else $error("new event lost in a status clear");

	a_irq_level: assert property (
		irq == |(int_status_reg & int_mask_reg))
		else $error("interrupt does not follow unmasked status");

	a_alarm_follows: assert property (
		(qual_wire && pg_sync_reg) |=> alarm_contact)
		else $error("alarm contact missed a qualified element");

	a_bus_okay: assert property (
		hreadyout && !hresp)
		else $error("bus slave stalled or answered an error");

endmodule : battery_monitor

// file: battery_monitor_pkg.sv
package battery_monitor_pkg;

	// ==========================================================
	// Widths
	localparam int VOLT_W = 16;
	localparam int PICKUP_W = 17;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int EV_W = 4;
	localparam int ROUTE_W = 2;
	localparam int QUAL_W = 16;

	// ==========================================================
	// Pickup range in hundredths of a volt
	localparam logic [VOLT_W-1:0] PICKUP_MIN = 16'h07d0;
	localparam logic [VOLT_W-1:0] PICKUP_MAX = 16'h7530;
	localparam int PICKUP_ON_BIT = 16;

	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFS_LOW_PICKUP = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_HIGH_PICKUP = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATE = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_METER = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_INT_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_INT_MASK = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_QUAL_DELAY = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_EVENT_VOLT = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_ROUTE = 8'h20;

	// ==========================================================
	// Field positions
	localparam int EV_UNDER = 0;
	localparam int EV_OVER = 1;
	localparam int EV_DIP = 2;
	localparam int EV_REPORT = 3;
	localparam int ROUTE_BAND_BIT = 0;
	localparam int ROUTE_LOCKOUT_BIT = 1;
	localparam int HTRANS_ACTIVE_BIT = 1;
	localparam int ST_UNDER_BIT = 0;
	localparam int ST_OVER_BIT = 1;
	localparam int ST_QUAL_BIT = 2;
	localparam int ST_POWER_BIT = 3;

	// ==========================================================
	// Reset values
	localparam logic [PICKUP_W-1:0] PICKUP_RST = 17'h00000;
	localparam logic [QUAL_W-1:0] QUAL_DELAY_RST = 16'h000a;
	localparam logic [ROUTE_W-1:0] ROUTE_RST = 2'h0;
	localparam logic [EV_W-1:0] EV_RST = 4'h0;
	localparam logic [VOLT_W-1:0] VOLT_RST = 16'h0000;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;

	// ==========================================================
	// Qualify timer states
	typedef enum logic [1:0] {
		Q_IDLE = 2'b00,
		Q_TIMING = 2'b01,
		Q_PICKED = 2'b10
	} qual_state_t;

	// Out of range settings are pulled to the nearest limit
	function automatic logic [VOLT_W-1:0] clamp_pickup(
		input logic [VOLT_W-1:0] v);
		logic [VOLT_W-1:0] r;
		r = v;
		if (v < PICKUP_MIN) begin
			r = PICKUP_MIN;
		end else if (v > PICKUP_MAX) begin
			r = PICKUP_MAX;
		end
		return r;
	endfunction : clamp_pickup

	// A pickup that is switched off never asserts
	function automatic logic pickup_flag(
		input logic [PICKUP_W-1:0] pu,
		input logic [VOLT_W-1:0] v,
		input logic high_side);
		logic r;
		r = 1'b0;
		if (pu[PICKUP_ON_BIT]) begin
			r = high_side ? (v >= pu[VOLT_W-1:0]) : (v <= pu[VOLT_W-1:0]);
		end
		return r;
	endfunction : pickup_flag

endpackage : battery_monitor_pkg

// file: battery_source.sv
`timescale 1ns/10ps
// ==========================================================
// Measurement source with selectable sample spacing
module battery_source
	import battery_monitor_pkg::*;
(
	input wire logic clk,
	input wire logic [battery_monitor_pkg::VOLT_W-1:0] level,
	input wire logic [3:0] lag,
	output logic [battery_monitor_pkg::VOLT_W-1:0] battery_voltage,
	output logic battery_valid
);
	logic [3:0] wait_cnt = 4'h0;

	// Inverted junk between samples; it toggles, so every second junk cycle carries the stale sample again
	always @(posedge clk) begin
		if (wait_cnt >= lag) begin
			wait_cnt <= 4'h0;
			battery_valid <= 1'b1;
			battery_voltage <= level;
		end else begin
			wait_cnt <= wait_cnt + 4'h1;
			battery_valid <= 1'b0;
			battery_voltage <= ~battery_voltage;
		end
	end
endmodule : battery_source

// file: qualify_timer.sv
`timescale 1ns/10ps
module qualify_timer
	import battery_monitor_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic element,
	input wire logic [battery_monitor_pkg::QUAL_W-1:0] delay,
	output logic qualified
);
	import battery_monitor_pkg::*;

	// ==========================================================
	// Pickup delay, immediate dropout
	qual_state_t state_reg;
	qual_state_t state_next;
	logic [QUAL_W-1:0] count_reg;
	logic [QUAL_W-1:0] count_next;
	logic qual_reg;
	logic qual_next;

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		qual_next = 1'b0;
		case (state_reg)
			Q_IDLE: begin
				count_next = '0;
				if (element) begin
					state_next = Q_TIMING;
				end
			end
			Q_TIMING: begin
				count_next = count_reg + 16'h0001;
				if (!element) begin
					state_next = Q_IDLE;
				end else if (count_reg >= delay) begin
					state_next = Q_PICKED;
					qual_next = 1'b1;
				end
			end
			Q_PICKED: begin
				qual_next = element;
				if (!element) begin
					state_next = Q_IDLE;
				end
			end
			default: begin
				state_next = Q_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state_reg <= Q_IDLE;
			count_reg <= '0;
			qual_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
			qual_reg <= qual_next;
		end
	end

	assign qualified = qual_reg;

endmodule : qualify_timer

// file: testbench.sv
`timescale 1ns/10ps
module testbench;
	import battery_monitor_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic trip = 1'b0;
	logic power_good_pin = 1'b1;
	logic [VOLT_W-1:0] level = 16'h0000;
	logic [3:0] lag = 4'h0;
	logic hreadyout, hresp, battery_valid, irq;
	logic undervoltage_flag, overvoltage_flag, qualified_battery_element;
	logic alarm_contact, reclose_lockout_drive, event_report_trigger;
	logic [31:0] hrdata, rd;
	logic [VOLT_W-1:0] battery_voltage, event_voltage, ev_v;
	logic [16:0] lo, hi;
	logic [31:0] seed = 32'h00008f2e;
	int err_total = 0;
	int n_tests = 0;
	int n_ev = 0;
	int evc;
	wire hready = hreadyout;

	always #50 clk = ~clk;

	battery_monitor dut_u (.clk(clk), .reset_n(reset_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .battery_voltage(battery_voltage),
		.battery_valid(battery_valid), .trip(trip),
		.power_good_pin(power_good_pin),
		.undervoltage_flag(undervoltage_flag),
		.overvoltage_flag(overvoltage_flag),
		.qualified_battery_element(qualified_battery_element),
		.alarm_contact(alarm_contact),
		.reclose_lockout_drive(reclose_lockout_drive),
		.event_report_trigger(event_report_trigger),
		.event_voltage(event_voltage), .irq(irq));

	battery_source src_u (.clk(clk), .level(level), .lag(lag),
		.battery_voltage(battery_voltage), .battery_valid(battery_valid));

	// ==========================================================
	// Event pulses last one cycle, so count them as they pass
	always @(posedge clk) begin
		if (event_report_trigger === 1'b1) begin
			n_ev <= n_ev + 1;
			ev_v <= event_voltage;
		end
	end

	// ==========================================================
	// Expectations
	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_step

	function automatic logic [15:0] clamp_exp(input logic [15:0] v);
		return (v < PICKUP_MIN) ? PICKUP_MIN : ((v > PICKUP_MAX) ? PICKUP_MAX : v);
	endfunction : clamp_exp

	function automatic logic flag_exp(input logic [16:0] pu,
		input logic [15:0] v, input logic up);
		return pu[16] & (up ? (v >= pu[15:0]) : (v <= pu[15:0]));
	endfunction : flag_exp

	// ==========================================================
	// Bus and check tasks
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic rd_chk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h00000000);
		check(what, exp, rd);
		check("hresp", 32'h0, hresp);
	endtask : rd_chk

	task automatic settle;
		@(posedge clk);
		repeat (int'(lag) + 6) @(posedge clk);
	endtask : settle

	// Raw values beyond the range must come back clamped
	task automatic set_pickup(input logic [7:0] a, output logic [16:0] pu);
		logic [15:0] raw;
		repeat (7) seed = lfsr_step(seed);
		raw = seed[16] ? seed[15:0] : PICKUP_MIN + {1'b0, seed[14:0]};
		pu = {seed[17] | seed[18], clamp_exp(raw)};
		bus(1'b1, a, {15'h0000, pu[16], raw});
		rd_chk("pickup", a, {15'h0000, pu});
	endtask : set_pickup

	// ==========================================================
	// Watchdog sized well past the expected run
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_of_test();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd_chk("low_rst", OFS_LOW_PICKUP, 32'h00000000);
		rd_chk("high_rst", OFS_HIGH_PICKUP, 32'h00000000);
		rd_chk("delay_rst", OFS_QUAL_DELAY, {16'h0000, QUAL_DELAY_RST});
		rd_chk("route_rst", OFS_ROUTE, 32'h00000000);
		rd_chk("mask_rst", OFS_INT_MASK, 32'h00000000);
		bus(1'b1, 8'h40, 32'h12345678);
		rd_chk("unmapped", 8'h40, 32'h00000000);
		for (int i = 0; i < 2; i++) begin
			level <= (i == 0) ? 16'h0000 : 16'hffff;
			settle();
			check("under_off", 32'h0, undervoltage_flag);
			check("over_off", 32'h0, overvoltage_flag);
		end
		for (int i = 0; i < 40; i++) begin
			set_pickup(OFS_LOW_PICKUP, lo);
			set_pickup(OFS_HIGH_PICKUP, hi);
			repeat (5) seed = lfsr_step(seed);
			case (seed[2:0])
				3'h0: level <= lo[15:0];
				3'h1: level <= lo[15:0] + 16'h0001;
				3'h2: level <= lo[15:0] - 16'h0001;
				3'h3: level <= hi[15:0];
				3'h4: level <= hi[15:0] + 16'h0001;
				3'h5: level <= hi[15:0] - 16'h0001;
				default: level <= seed[31:16];
			endcase
			lag <= {2'h0, seed[4:3]};
			settle();
			check("under", flag_exp(lo, level, 1'b0), undervoltage_flag);
			check("over", flag_exp(hi, level, 1'b1), overvoltage_flag);
			rd_chk("meter", OFS_METER, {16'h0000, level});
		end
		lag <= 4'h0;
		bus(1'b1, OFS_LOW_PICKUP, 32'h00013a98);
		bus(1'b1, OFS_HIGH_PICKUP, 32'h00012710);
		bus(1'b1, OFS_QUAL_DELAY, 32'h00000003);
		bus(1'b1, OFS_ROUTE, 32'h00000003);
		level <= 16'h2ee0;
		repeat (12) @(posedge clk);
		check("qualified", 32'h1, qualified_battery_element);
		check("alarm", 32'h1, alarm_contact);
		check("lockout_idle", 32'h0, reclose_lockout_drive);
		check("irq_masked", 32'h0, irq);
		bus(1'b1, OFS_INT_STATUS, 32'h0000000f);
		bus(1'b1, OFS_INT_MASK, 32'h00000004);
		evc = n_ev;
		level <= 16'h2328;
		settle();
		check("dropout", 32'h0, qualified_battery_element);
		check("lockout", 32'h1, reclose_lockout_drive);
		check("dip_events", evc + 1, n_ev);
		check("dip_volt", 32'h2328, {16'h0000, ev_v});
		check("irq_set", 32'h1, irq);
		rd_chk("event_volt", OFS_EVENT_VOLT, 32'h00002328);
		rd_chk("state", OFS_STATE, 32'h00000009);
		rd_chk("status", OFS_INT_STATUS, 32'h0000000c);
		bus(1'b1, OFS_INT_STATUS, 32'h00000004);
		repeat (2) @(posedge clk);
		check("irq_clear", 32'h0, irq);
		rd_chk("status_left", OFS_INT_STATUS, 32'h00000008);
		power_good_pin <= 1'b0;
		repeat (5) @(posedge clk);
		check("lockout_dead", 32'h0, reclose_lockout_drive);
		power_good_pin <= 1'b1;
		level <= 16'h2ee0;
		repeat (12) @(posedge clk);
		power_good_pin <= 1'b0;
		repeat (5) @(posedge clk);
		check("alarm_dead", 32'h0, alarm_contact);
		power_good_pin <= 1'b1;
		evc = n_ev;
		trip <= 1'b1;
		@(posedge clk);
		trip <= 1'b0;
		@(posedge clk);
		trip <= 1'b1;
		repeat (5) @(posedge clk);
		trip <= 1'b0;
		repeat (3) @(posedge clk);
		check("trip_events", evc + 2, n_ev);
		check("trip_volt", 32'h2ee0, {16'h0000, ev_v});
		end_of_test();
	end
endmodule : testbench
